/* File: logic/adc_sample_convert_control.sv */
// converter control register block with axi4-lite slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module adc_sample_convert_control #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              MCLK,
	input  wire logic              SRST,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	// axi4-lite write data
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	// system state and trigger sources
	input  wire logic              IDLE_MODE,
	input  wire logic              EXT_IRQ_PIN_ZERO,
	input  wire logic              TIMER3_MATCH,
	input  wire logic              CHARGE_TIME_EVENT,
	// analog converter core
	input  wire logic              CONV_DONE,
	input  wire logic [9:0]        CONV_RESULT,
	output logic                   MODULE_ACTIVE,
	output logic                   SAMPLE_EN,
	output logic                   CONV_START
);

	// ========================================
	// declarations
	adc_ctrl_pkg::ctrl_t   ctrl_r;
	adc_ctrl_pkg::cstate_t state_r;
	adc_ctrl_pkg::cstate_t state_nxt;
	logic              done_r;
	logic [9:0]        result_r;
	logic [7:0]        smpt_r;
	logic [7:0]        cnt_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic              aw_held_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              w_held_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [1:0]        rresp_r;
	logic [31:0]       rdata_r;
	logic              ext_s1_r;
	logic              ext_s2_r;
	logic              ext_s3_r;
	logic              start_r;
	logic              run;
	logic              wr_go;
	logic              wr_ctrl;
	logic              wr_smpt;
	logic              wr_map;
	logic              sample_bit_wr;
	logic              sw_start;
	logic              sw_end;
	logic              ext_edge;
	logic              cnt_hit;
	logic              trig;
	logic              conv_end;
	logic [31:0]       ctrl_rd;
	logic [31:0]       ctrl_wr;

	// ========================================
	// helper functions

	// merges write data into a word under the byte strobes
	function automatic logic [31:0] strb_merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : strb_merge

	// presents the raw sample in the selected output format
	function automatic logic [31:0] fmt_result(
		input logic [2:0] f,
		input logic [9:0] d
	);
		logic [9:0]  s;
		logic [31:0] res;
		s = {~d[9], d[8:0]}; // offset binary to two's complement
		case (f)
			adc_ctrl_pkg::FMT_INT16,
			adc_ctrl_pkg::FMT_INT32: res = {22'h000000, d};
			adc_ctrl_pkg::FMT_SINT32: res = {{22{s[9]}}, s};
			adc_ctrl_pkg::FMT_FRAC16: res = {16'h0000, d, 6'h00};
			adc_ctrl_pkg::FMT_FRAC32: res = {d, 22'h000000};
			adc_ctrl_pkg::FMT_SFRAC16: res = {16'h0000, s, 6'h00};
			adc_ctrl_pkg::FMT_SFRAC32: res = {s, 22'h000000};
			default: res = 32'h00000000; // undefined code reads zero
		endcase
		return res;
	endfunction : fmt_result

	// ========================================
	// axi4-lite write channels

	// address and data are held apart and taken in either order
	assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
	assign S_AXI_WREADY  = !w_held_r && !bvalid_r;
	assign S_AXI_BVALID  = bvalid_r;
	assign S_AXI_BRESP   = bresp_r;
	assign wr_go         = aw_held_r && w_held_r && !bvalid_r;

	// write address holding register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= S_AXI_AWADDR;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	// write data holding register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held_r <= 1'b1;
			wdata_r  <= S_AXI_WDATA;
			wstrb_r  <= S_AXI_WSTRB;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	// write address decode
	always_comb begin
		wr_ctrl = 1'b0;
		wr_smpt = 1'b0;
		wr_map  = 1'b1;
		if (awaddr_r[7:0] == adc_ctrl_pkg::CTRL_OFS) begin
			wr_ctrl = wr_go;
		end else if (awaddr_r[7:0] == adc_ctrl_pkg::SMPT_OFS) begin
			wr_smpt = wr_go;
		end else if (awaddr_r[7:0] == adc_ctrl_pkg::RESULT_OFS) begin
			wr_map = 1'b1; // read-only, write ignored
		end else begin
			wr_map = 1'b0;
		end
	end

	// write response, error for an unmapped address
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			bvalid_r <= 1'b0;
			bresp_r  <= adc_ctrl_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_map ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	// ========================================
	// axi4-lite read channels
	assign S_AXI_ARREADY = !rvalid_r;
	assign S_AXI_RVALID  = rvalid_r;
	assign S_AXI_RDATA   = rdata_r;
	assign S_AXI_RRESP   = rresp_r;

	// control word as software sees it, gaps read zero
	always_comb begin
		ctrl_rd = 32'h00000000;
		ctrl_rd[adc_ctrl_pkg::ON_BIT]                  = ctrl_r.on;
		ctrl_rd[adc_ctrl_pkg::IDLE_STOP_BIT]                = ctrl_r.idle_stop;
		ctrl_rd[adc_ctrl_pkg::OUTPUT_FORMAT_LSB +: 3]           = ctrl_r.output_format;
		ctrl_rd[adc_ctrl_pkg::TRIGGER_SOURCE_LSB +: 3]           = ctrl_r.trigger_source;
		ctrl_rd[adc_ctrl_pkg::AUTO_SAMPLE_CLEAR_BIT]             = ctrl_r.auto_sample_clear;
		ctrl_rd[adc_ctrl_pkg::AUTO_SAMPLE_BIT]                = ctrl_r.auto_sample;
		ctrl_rd[adc_ctrl_pkg::SAMPLE_BIT_BIT]                = (state_r == adc_ctrl_pkg::ST_SAMPLE);
		ctrl_rd[adc_ctrl_pkg::DONE_BIT]                = done_r;
	end

	// control word after a write, kept bytes come from the current value
	assign ctrl_wr = strb_merge(ctrl_rd, wdata_r, wstrb_r);

	// read data and response, answered one cycle after the address
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= adc_ctrl_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_r <= 1'b1;
			rresp_r  <= adc_ctrl_pkg::RESP_OKAY;
			if (S_AXI_ARADDR[7:0] == adc_ctrl_pkg::CTRL_OFS) begin
				rdata_r <= ctrl_rd;
			end else if (S_AXI_ARADDR[7:0] == adc_ctrl_pkg::RESULT_OFS) begin
				rdata_r <= fmt_result(ctrl_r.output_format, result_r);
			end else if (S_AXI_ARADDR[7:0] == adc_ctrl_pkg::SMPT_OFS) begin
				rdata_r <= {24'h000000, smpt_r};
			end else begin
				rdata_r <= 32'h00000000;
				rresp_r <= adc_ctrl_pkg::RESP_SLVERR;
			end
		end else if (S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	// ========================================
	// trigger inputs

	// external pin passes two flops, the third feeds the edge detect
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end else begin
			ext_s1_r <= EXT_IRQ_PIN_ZERO;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	assign ext_edge = ext_s2_r && !ext_s3_r; // rising edge is the active one

	// module runs when enabled and not stopped by idle
	assign run = ctrl_r.on && !(ctrl_r.idle_stop && IDLE_MODE);

	// sampling-time counter for the internal trigger
	always_ff @(posedge MCLK) begin
		if (SRST || !ctrl_r.on || state_r != adc_ctrl_pkg::ST_SAMPLE) begin
			cnt_r <= 8'h00;
		end else if (run && !cnt_hit) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	assign cnt_hit = (cnt_r + 8'h01 >= smpt_r);

	// software sample bit requests
	assign sample_bit_wr  = wr_ctrl && wstrb_r[0];
	assign sw_start = sample_bit_wr && wdata_r[adc_ctrl_pkg::SAMPLE_BIT_BIT] && !ctrl_r.auto_sample;
	assign sw_end   = sample_bit_wr && !wdata_r[adc_ctrl_pkg::SAMPLE_BIT_BIT]
		&& ctrl_r.trigger_source == adc_ctrl_pkg::SRC_MANUAL;

	// selected source ends sampling
	always_comb begin
		case (ctrl_r.trigger_source)
			adc_ctrl_pkg::SRC_MANUAL: trig = sw_end;
			adc_ctrl_pkg::SRC_EXTIRQ: trig = ext_edge;
			adc_ctrl_pkg::SRC_TIMER3: trig = TIMER3_MATCH;
			adc_ctrl_pkg::SRC_CTU:    trig = CHARGE_TIME_EVENT;
			adc_ctrl_pkg::SRC_AUTO:   trig = cnt_hit;
			default:                  trig = 1'b0; // reserved codes never trigger
		endcase
	end

	// ========================================
	// sample / convert sequencer

	// next state of the sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			adc_ctrl_pkg::ST_IDLE: begin
				if (ctrl_r.auto_sample || sw_start) begin
					state_nxt = adc_ctrl_pkg::ST_SAMPLE;
				end
			end
			adc_ctrl_pkg::ST_SAMPLE: begin
				if (trig) begin
					state_nxt = adc_ctrl_pkg::ST_CONV;
				end
			end
			adc_ctrl_pkg::ST_CONV: begin
				if (CONV_DONE) begin
					state_nxt = adc_ctrl_pkg::ST_IDLE;
				end
			end
			default: state_nxt = adc_ctrl_pkg::ST_IDLE;
		endcase
	end

	assign conv_end = run && state_r == adc_ctrl_pkg::ST_CONV && CONV_DONE;

	// state register, frozen while halted, cleared while disabled
	always_ff @(posedge MCLK) begin
		if (SRST || !ctrl_r.on) begin
			state_r <= adc_ctrl_pkg::ST_IDLE;
		end else if (run) begin
			state_r <= state_nxt;
		end
	end

	// one-cycle start pulse to the core
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			start_r <= 1'b0;
		end else begin
			start_r <= run && state_r == adc_ctrl_pkg::ST_SAMPLE && trig;
		end
	end

	// latches the raw sample at the end of conversion
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			result_r <= 10'h000;
		end else if (conv_end) begin
			result_r <= CONV_RESULT;
		end
	end

	// conversion-complete flag, hardware set wins over software clear
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			done_r <= 1'b0;
		end else if (conv_end) begin
			done_r <= 1'b1;
		end else if (run && state_r == adc_ctrl_pkg::ST_SAMPLE && trig) begin
			done_r <= 1'b0;
		end else if (sample_bit_wr && !wdata_r[adc_ctrl_pkg::DONE_BIT]) begin
			done_r <= 1'b0;
		end
	end

	// ========================================
	// writable control fields
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			ctrl_r <= adc_ctrl_pkg::CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= adc_ctrl_pkg::ctrl_t'({
					ctrl_wr[adc_ctrl_pkg::ON_BIT],
					ctrl_wr[adc_ctrl_pkg::IDLE_STOP_BIT],
					ctrl_wr[adc_ctrl_pkg::OUTPUT_FORMAT_LSB +: 3],
					ctrl_wr[adc_ctrl_pkg::TRIGGER_SOURCE_LSB +: 3],
					ctrl_wr[adc_ctrl_pkg::AUTO_SAMPLE_CLEAR_BIT],
					ctrl_wr[adc_ctrl_pkg::AUTO_SAMPLE_BIT]
				});
			end
			// auto-sample stops after one conversion when asked
			if (conv_end && ctrl_r.auto_sample_clear) begin
				ctrl_r.auto_sample <= 1'b0;
			end
		end
	end

	// sampling time for the internal counter
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			smpt_r <= adc_ctrl_pkg::SMPT_RST;
		end else if (wr_smpt && wstrb_r[0]) begin
			smpt_r <= wdata_r[7:0];
		end
	end

	// ========================================
	// core outputs
	assign MODULE_ACTIVE = run;
	assign SAMPLE_EN     = run && state_r == adc_ctrl_pkg::ST_SAMPLE;
	assign CONV_START    = start_r;

endmodule : adc_sample_convert_control

/* File: logic/adc_ctrl_pkg.sv */
// constants and types shared by the converter control block
package adc_ctrl_pkg;

	// ========================================
	// register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] RESULT_OFS = 8'h04;
	localparam logic [7:0] SMPT_OFS   = 8'h08;

	// ========================================
	// control register field positions
	localparam int ON_BIT      = 15;
	localparam int IDLE_STOP_BIT    = 13;
	localparam int OUTPUT_FORMAT_LSB    = 8;
	localparam int TRIGGER_SOURCE_LSB    = 5;
	localparam int AUTO_SAMPLE_CLEAR_BIT = 4;
	localparam int AUTO_SAMPLE_BIT    = 2;
	localparam int SAMPLE_BIT_BIT    = 1;
	localparam int DONE_BIT    = 0;

	// ========================================
	// output format codes
	localparam logic [2:0] FMT_INT16   = 3'h0;
	localparam logic [2:0] FMT_FRAC16  = 3'h2;
	localparam logic [2:0] FMT_SFRAC16 = 3'h3;
	localparam logic [2:0] FMT_INT32   = 3'h4;
	localparam logic [2:0] FMT_SINT32  = 3'h5;
	localparam logic [2:0] FMT_FRAC32  = 3'h6;
	localparam logic [2:0] FMT_SFRAC32 = 3'h7;

	// ========================================
	// trigger source codes
	localparam logic [2:0] SRC_MANUAL = 3'h0;
	localparam logic [2:0] SRC_EXTIRQ = 3'h1;
	localparam logic [2:0] SRC_TIMER3 = 3'h2;
	localparam logic [2:0] SRC_CTU    = 3'h3;
	localparam logic [2:0] SRC_AUTO   = 3'h7;

	// ========================================
	// reset values and bus answers
	localparam logic [7:0] SMPT_RST   = 8'h04;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// writable control fields
	typedef struct packed {
		logic       on;
		logic       idle_stop;
		logic [2:0] output_format;
		logic [2:0] trigger_source;
		logic       auto_sample_clear;
		logic       auto_sample;
	} ctrl_t;

	localparam ctrl_t CTRL_RST = '0;

	// sample / convert sequencer
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONV   = 3'b100
	} cstate_t;

endpackage : adc_ctrl_pkg

/* File: sim/adc_ctrl_checker.sv */
// port assertions for the converter control block
`timescale 1ns/1ps

module adc_ctrl_checker #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              MCLK,
	input wire logic              SRST,
	// register bus
	input wire logic              S_AXI_AWVALID,
	input wire logic              S_AXI_AWREADY,
	input wire logic              S_AXI_WVALID,
	input wire logic              S_AXI_WREADY,
	input wire logic              S_AXI_BVALID,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic              S_AXI_ARVALID,
	input wire logic              S_AXI_ARREADY,
	input wire logic [31:0]       S_AXI_RDATA,
	input wire logic [1:0]        S_AXI_RRESP,
	input wire logic              S_AXI_RVALID,
	// converter side
	input wire logic              MODULE_ACTIVE,
	input wire logic              SAMPLE_EN,
	input wire logic              CONV_START
);
	// ============
	// one clock domain throughout
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);

	reset_clear_a: assert property (disable iff (1'b0) SRST |=> !MODULE_ACTIVE && !SAMPLE_EN
		&& !CONV_START) else $error("outputs not idle after reset");
	start_pulse_a: assert property (CONV_START |=> !CONV_START)
		else $error("start pulse longer than one cycle");
	start_stops_a: assert property (CONV_START |-> !SAMPLE_EN)
		else $error("sampling still on at start");
	start_cause_a: assert property ($rose(CONV_START) |-> $past(SAMPLE_EN) || $past(SAMPLE_EN, 2))
		else $error("start without sampling");
	inactive_quiet_a: assert property (!MODULE_ACTIVE |-> !SAMPLE_EN)
		else $error("sampling while module off");
	ctrl_zeros_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 0
		|=> S_AXI_RVALID && S_AXI_RDATA[31:16] == 16'h0 && !S_AXI_RDATA[14]
		&& S_AXI_RDATA[12:11] == 2'h0 && !S_AXI_RDATA[3]) else $error("unimplemented bits set");
	unmapped_err_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h0b
		|=> S_AXI_RRESP == adc_ctrl_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
		else $error("unmapped read not refused");
	write_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while response pending");
	write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |=> ##[0:2] S_AXI_BVALID) else $error("write response missing");
	read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
		|=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer missing");
endmodule : adc_ctrl_checker

bind adc_sample_convert_control adc_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (
	.MCLK, .SRST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
	.S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
	.S_AXI_RRESP, .S_AXI_RVALID, .MODULE_ACTIVE, .SAMPLE_EN, .CONV_START
);

/* File: sim/adc_core_model.sv */
// behavioural analog converter core
`timescale 1ns/1ps

module adc_core_model #(
	parameter int LAT = 12
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// control and sample
	input wire logic       start,
	input wire logic [9:0] value,
	output logic           done,
	output logic [9:0]     result
);
	int         cnt_r;
	logic [9:0] res_r;

	// ============
	// conversion timer: done pulses LAT cycles after start
	always_ff @(posedge clk) begin
		if (rst)
			cnt_r <= 0;
		else if (start)
			cnt_r <= LAT;
		else if (cnt_r != 0)
			cnt_r <= cnt_r - 1;
	end
	assign done = (cnt_r == 1);

	// result is valid only beside done, otherwise it flips every cycle
	always_ff @(posedge clk) begin
		if (rst)
			res_r <= 10'h155;
		else
			res_r <= (cnt_r == 2) ? value : ~res_r;
	end
	assign result = res_r;
endmodule : adc_core_model

/* File: sim/test_adc_sample_convert_control.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps

module test_adc_sample_convert_control;
	// ============
	// signals
	logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, idle, ext, tmr, ctu, cdone, act, sen, cst;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rdv;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsv;
	logic [9:0]  cres, smp;
	logic [2:0]  fl [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	int          errors, samples_checked;

	// clock at 20 MHz
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	adc_sample_convert_control u_dut (
		.MCLK(clk), .SRST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.IDLE_MODE(idle), .EXT_IRQ_PIN_ZERO(ext), .TIMER3_MATCH(tmr),
		.CHARGE_TIME_EVENT(ctu), .CONV_DONE(cdone), .CONV_RESULT(cres),
		.MODULE_ACTIVE(act), .SAMPLE_EN(sen), .CONV_START(cst));

	adc_core_model u_core (.clk(clk), .rst(rst), .start(cst), .value(smp),
		.done(cdone), .result(cres));

	// ============
	// tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, e;
		@(posedge clk);
		{awaddr, wdata, wstrb} <= {a, d, 4'hf};
		{awvalid, wvalid, bready} <= 3'b111;
		do begin
			@(negedge clk);
			{ha, hw, e} = {awvalid & awready, wvalid & wready, bvalid};
			rsv = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end while (!e);
		bready <= 1'b0;
		chk("bresp", 32'h0, {30'h0, rsv});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		logic h, e;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do begin
			@(negedge clk);
			{h, e, rdv, rsv} = {arvalid & arready, rvalid, rdata, rresp};
			@(posedge clk);
			if (h) arvalid <= 1'b0;
		end while (!e);
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rsv});
	endtask : rd

	task automatic wait_done(input logic w);
		int n;
		n = 0;
		do begin
			rd(adc_ctrl_pkg::CTRL_OFS, 2'h0);
			n++;
		end while (rdv[0] !== w && n < 60);
		chk("done flag", {31'h0, w}, {31'h0, rdv[0]});
	endtask : wait_done

	task automatic pulse(input logic [2:0] m);
		@(posedge clk);
		{ctu, tmr, ext} <= m;
		@(posedge clk);
		{ctu, tmr} <= 2'h0;
		repeat (4) @(posedge clk);
		ext <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse

	function automatic logic [31:0] fmt(input logic [2:0] f, input logic [9:0] d);
		logic [9:0] s;
		s = {~d[9], d[8:0]};
		case (f)
			3'h2: fmt = {16'h0, d, 6'h0};
			3'h3: fmt = {16'h0, s, 6'h0};
			3'h5: fmt = {{22{s[9]}}, s};
			3'h6: fmt = {d, 22'h0};
			3'h7: fmt = {s, 22'h0};
			default: fmt = {22'h0, d};
		endcase
	endfunction : fmt

	task stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// watchdog
	initial begin
		#1000000;
		errors++;
		stop_test;
	end

	// ============
	// main sequence
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, idle, ext, tmr, ctu} = '0;
		{awaddr, araddr, wdata, wstrb, smp} = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(adc_ctrl_pkg::CTRL_OFS, 2'h0);
		chk("ctrl reset", 32'h0, rdv);
		rd(adc_ctrl_pkg::SMPT_OFS, 2'h0);
		chk("sample time", {24'h0, adc_ctrl_pkg::SMPT_RST}, rdv);
		rd(8'h0c, adc_ctrl_pkg::RESP_SLVERR);
		chk("unmapped", 32'h0, rdv);
		wr(adc_ctrl_pkg::CTRL_OFS, 32'hffff7fff);
		rd(adc_ctrl_pkg::CTRL_OFS, 2'h0);
		chk("ctrl fields", 32'h000027f4, rdv);
		$display("end register map test");
		wr(adc_ctrl_pkg::SMPT_OFS, 32'h3);
		// enable first: a sample request in the enabling write is not taken
		wr(adc_ctrl_pkg::CTRL_OFS, 32'h00008000);
		foreach (fl[i]) begin
			smp <= i[0] ? 10'h2c5 : 10'h13a;
			wr(adc_ctrl_pkg::CTRL_OFS, {16'h0, 5'h10, fl[i], 8'h02});
			rd(adc_ctrl_pkg::CTRL_OFS, 2'h0);
			chk("sampling", {16'h0, 5'h10, fl[i], 8'h02}, rdv);
			wr(adc_ctrl_pkg::CTRL_OFS, {16'h0, 5'h10, fl[i], 8'h00});
			rd(adc_ctrl_pkg::CTRL_OFS, 2'h0);
			chk("converting", {16'h0, 5'h10, fl[i], 8'h00}, rdv);
			wait_done(1'b1);
			rd(adc_ctrl_pkg::RESULT_OFS, 2'h0);
			chk("result", fmt(fl[i], smp), rdv);
		end
		$display("end format test");
		for (int s = 1; s < 4; s++) begin
			wr(adc_ctrl_pkg::CTRL_OFS, {16'h0, 8'h80, s[2:0], 5'h02});
			pulse(3'(7 ^ (1 << (s - 1))));
			rd(adc_ctrl_pkg::CTRL_OFS, 2'h0);
			chk("other source", {16'h0, 8'h80, s[2:0], 5'h02}, rdv);
			pulse(3'(1 << (s - 1)));
			wait_done(1'b1);
			chk("sample cleared", 32'h0, {31'h0, rdv[1]});
		end
		$display("end trigger test");
		// long sampling keeps the complete flag up longer than one poll
		wr(adc_ctrl_pkg::SMPT_OFS, 32'h20);
		wr(adc_ctrl_pkg::CTRL_OFS, 32'h000080e4);
		wait_done(1'b1);
		wait_done(1'b0);
		wait_done(1'b1);
		$display("end auto test");
		idle <= 1'b1;
		wr(adc_ctrl_pkg::CTRL_OFS, 32'h0000a0e4);
		@(negedge clk);
		chk("halted", 32'h0, {31'h0, act});
		wr(adc_ctrl_pkg::CTRL_OFS, 32'h000080e4);
		@(negedge clk);
		chk("idle run", 32'h1, {31'h0, act});
		idle <= 1'b0;
		wr(adc_ctrl_pkg::CTRL_OFS, 32'h0);
		@(negedge clk);
		chk("off", 32'h0, {31'h0, act});
		repeat (2) @(posedge clk);
		wr(adc_ctrl_pkg::CTRL_OFS, 32'h0);
		rd(adc_ctrl_pkg::CTRL_OFS, 2'h0);
		chk("ctrl off", 32'h0, rdv);
		$display("end idle test");
		stop_test;
	end
endmodule : test_adc_sample_convert_control
